// >>> rtl/svc_cfg.svh
`ifndef SVC_CFG_SVH
`define SVC_CFG_SVH
`define SVC_OP1_MAIN 3'h0
`define SVC_CRN_CTRL 4'h1
`define SVC_CRN_TTB 4'h2
`define SVC_CRN_NONE 4'h4
`define SVC_CRN_CACHE 4'h7
`define SVC_CRN_TLB 4'h8
`define SVC_CRN_PRELOAD 4'hb
`define SVC_CRM_C0 4'h0
`define SVC_CRM_C1 4'h1
`define SVC_CRM_TLB_SHARED 4'h3
`define SVC_CRM_TLB_LO 4'h5
`define SVC_CRM_TLB_HI 4'h7
`define SVC_OP2_AUX 3'h1
`define SVC_OP2_CPACC 3'h2
`define SVC_OP2_NSAC 3'h2
`define SVC_OP2_VIRT 3'h3
`define SVC_OP2_TBC 3'h2
`define SVC_OP2_NOP 3'h4
`define SVC_NSAC_COH 18
`define SVC_NSAC_LOCK_ALLOC 17
`define SVC_NSAC_PRE 16
`define SVC_NSAC_VEC 15
`define SVC_NSAC_FP 14
`define SVC_NSAC_ELEVEN 11
`define SVC_NSAC_TEN 10
`define SVC_VIRT_ABT 8
`define SVC_VIRT_IRQ 7
`define SVC_VIRT_FIQ 6
`define SVC_AUX_COH 6
`define SVC_CPA_VEC 31
`define SVC_CPA_FP 30
`define SVC_CPA_ELEVEN_HI 23
`define SVC_CPA_ELEVEN_LO 22
`define SVC_CPA_TEN_HI 21
`define SVC_CPA_TEN_LO 20
`define SVC_NSAC_WMASK 32'h0007_cc00
`define SVC_VIRT_WMASK 32'h0000_01c0
`define SVC_CPA_WMASK 32'hc0f0_0000
`define SVC_NSAC_RST 32'h0000_0000
`define SVC_VIRT_RST 32'h0000_0000
`define SVC_CPA_RST 32'h0000_0000
`define SVC_TBC_RST 32'h0000_0000
`endif

// >>> rtl/svc_pkg.sv
package svc_pkg;
    typedef enum logic [1:0] {
        SVC_TLBI_ALL = 2'h0,
        SVC_TLBI_MVA = 2'h1,
        SVC_TLBI_ASID = 2'h2,
        SVC_TLBI_MVAA = 2'h3
    } svc_tlbi_t;
endpackage

// >>> rtl/svc_regs.sv
`timescale 1ns/1ps
`include "svc_cfg.svh"
// Overview of operation
// - Access register: privileged only, read-only when non-secure.
// - Permit clear: non-secure aux write undefined.
// - Permit set: non-secure aux write changes coherency only.
// - Bit 17 permits non-secure lockable cache allocation.
// - Bit 16 clear traps non-secure c11 accesses.
// - Without preload engine, bit 16 reads zero.
// - Bit 15 forces vector disable when non-secure.
// - Bit 14 forces upper bank disable when non-secure.
// - Bit 11 grants non-secure coprocessor 11 access.
// - Bit 10 grants non-secure coprocessor 10 access.
// - Access register sits at c1, c1, 2.
// - Virtualization register: secure privileged only, c1 c1 3.
// - Abort override applies when non-secure and routed.
// - IRQ override applies when non-secure and routed.
// - FIQ override applies when non-secure and routed.
// - Overrides ignored in secure state or unrouted.
// - Only secure table control copy resets to zero.
// - Invalidate-all kinds spare locked entries.
// - Address and space kinds hit matching locked entries.
// - c7 c0 4 write acts as wait-for-interrupt.
// - Nothing is implemented under c4.
module svc_regs import svc_pkg::*; #(
    parameter bit PRELOAD_PRESENT = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cp_req_in,
    input wire logic cp_write_in,
    input wire logic [2:0] cp_op1_in,
    input wire logic [3:0] cp_crn_in,
    input wire logic [3:0] cp_crm_in,
    input wire logic [2:0] cp_op2_in,
    input wire logic [31:0] cp_wdata_in,
    input wire logic cp_priv_in,
    input wire logic secure_state_in,
    input wire logic route_abort_in,
    input wire logic route_irq_in,
    input wire logic route_fiq_in,
    input wire logic mask_abort_in,
    input wire logic mask_irq_in,
    input wire logic mask_fiq_in,
    input wire logic pend_abort_in,
    input wire logic pend_irq_in,
    input wire logic pend_fiq_in,
    output logic cp_done_out,
    output logic cp_undef_out,
    output logic [31:0] cp_rdata_out,
    output logic take_abort_out,
    output logic take_irq_out,
    output logic take_fiq_out,
    output logic copro_ten_ok_out,
    output logic copro_eleven_ok_out,
    output logic lockable_alloc_ok_out,
    output logic preload_ok_out,
    output logic coherency_participation_out,
    output logic vector_ext_disable_out,
    output logic upper_fp_bank_disable_out,
    output logic tlb_inv_out,
    output svc_tlbi_t tlb_inv_kind_out,
    output logic tlb_inv_hit_locked_out,
    output logic tlb_inv_shared_out,
    output logic [31:0] tlb_inv_arg_out,
    output logic wait_for_interrupt_action_out
);
    // ****************************************
    // Storage.
    // ****************************************
    logic [31:0] nsac_q;
    logic [31:0] virt_q;
    logic [31:0] cpa_q;
    logic [31:0] tbc_s_q;
    logic [31:0] tbc_ns_q;
    logic coh_q;
    logic [31:0] nsac_wmask;
    logic ns;
    logic main_op1;
    logic hit_aux, hit_cpa, hit_nsac, hit_virt, hit_tbc, hit_nop, hit_pre, hit_tlb;
    logic tlb_is_op, tlb_locked, tlb_shared;
    svc_tlbi_t tlb_kind;
    logic undef_d;
    logic wr_ok;
    logic [31:0] cpa_view;
    logic [31:0] cpa_wmask;
    logic [31:0] rdata_d;

    // ****************************************
    // Decode.
    // ****************************************
    assign ns = !secure_state_in;
    assign main_op1 = (cp_op1_in == `SVC_OP1_MAIN);
    assign nsac_wmask = PRELOAD_PRESENT ? `SVC_NSAC_WMASK
        : (`SVC_NSAC_WMASK & ~(32'h1 << `SVC_NSAC_PRE));
    assign hit_aux = main_op1 && cp_crn_in == `SVC_CRN_CTRL
        && cp_crm_in == `SVC_CRM_C0 && cp_op2_in == `SVC_OP2_AUX;
    assign hit_cpa = main_op1 && cp_crn_in == `SVC_CRN_CTRL
        && cp_crm_in == `SVC_CRM_C0 && cp_op2_in == `SVC_OP2_CPACC;
    assign hit_nsac = main_op1 && cp_crn_in == `SVC_CRN_CTRL
        && cp_crm_in == `SVC_CRM_C1 && cp_op2_in == `SVC_OP2_NSAC;
    assign hit_virt = main_op1 && cp_crn_in == `SVC_CRN_CTRL
        && cp_crm_in == `SVC_CRM_C1 && cp_op2_in == `SVC_OP2_VIRT;
    assign hit_tbc = main_op1 && cp_crn_in == `SVC_CRN_TTB
        && cp_crm_in == `SVC_CRM_C0 && cp_op2_in == `SVC_OP2_TBC;
    assign hit_nop = main_op1 && cp_crn_in == `SVC_CRN_CACHE && cp_write_in
        && cp_crm_in == `SVC_CRM_C0 && cp_op2_in == `SVC_OP2_NOP;
    assign hit_pre = main_op1 && cp_crn_in == `SVC_CRN_PRELOAD;
    assign hit_tlb = main_op1 && cp_crn_in == `SVC_CRN_TLB && cp_write_in && tlb_is_op;

    svc_tlb_decode u_tlb_decode (
        .crm_in(cp_crm_in),
        .op2_in(cp_op2_in),
        .is_op_out(tlb_is_op),
        .kind_out(tlb_kind),
        .hit_locked_out(tlb_locked),
        .shared_out(tlb_shared)
    );

    // ****************************************
    // Access checks.
    // ****************************************
    always_comb begin
        undef_d = 1'b0;
        if (!cp_priv_in) begin
            undef_d = 1'b1;
        end else if (ns && hit_nsac && cp_write_in) begin
            undef_d = 1'b1;
        end else if (ns && hit_virt) begin
            undef_d = 1'b1;
        end else if (ns && hit_aux && cp_write_in && !nsac_q[`SVC_NSAC_COH]) begin
            undef_d = 1'b1;
        end else if (ns && hit_pre && !nsac_q[`SVC_NSAC_PRE]) begin
            undef_d = 1'b1;
        end else if (!(hit_aux || hit_cpa || hit_nsac || hit_virt || hit_tbc
                || hit_nop || hit_pre || hit_tlb)) begin
            undef_d = 1'b1;
        end
    end
    assign wr_ok = cp_req_in && cp_write_in && !undef_d;

    // ****************************************
    // Coprocessor access view.
    // ****************************************
    always_comb begin
        cpa_view = cpa_q;
        cpa_wmask = `SVC_CPA_WMASK;
        if (ns) begin
            if (nsac_q[`SVC_NSAC_VEC]) begin
                cpa_view[`SVC_CPA_VEC] = 1'b1;
                cpa_wmask[`SVC_CPA_VEC] = 1'b0;
            end
            if (nsac_q[`SVC_NSAC_FP]) begin
                cpa_view[`SVC_CPA_FP] = 1'b1;
                cpa_wmask[`SVC_CPA_FP] = 1'b0;
            end
            if (!nsac_q[`SVC_NSAC_ELEVEN]) begin
                cpa_view[`SVC_CPA_ELEVEN_HI:`SVC_CPA_ELEVEN_LO] = 2'h0;
                cpa_wmask[`SVC_CPA_ELEVEN_HI:`SVC_CPA_ELEVEN_LO] = 2'h0;
            end
            if (!nsac_q[`SVC_NSAC_TEN]) begin
                cpa_view[`SVC_CPA_TEN_HI:`SVC_CPA_TEN_LO] = 2'h0;
                cpa_wmask[`SVC_CPA_TEN_HI:`SVC_CPA_TEN_LO] = 2'h0;
            end
        end
    end

    // ****************************************
    // Read data.
    // ****************************************
    always_comb begin
        rdata_d = 32'h0;
        if (cp_req_in && !cp_write_in && !undef_d) begin
            if (hit_nsac) begin
                rdata_d = nsac_q;
            end else if (hit_virt) begin
                rdata_d = virt_q;
            end else if (hit_cpa) begin
                rdata_d = cpa_view;
            end else if (hit_aux) begin
                rdata_d[`SVC_AUX_COH] = coh_q;
            end else if (hit_tbc) begin
                rdata_d = ns ? tbc_ns_q : tbc_s_q;
            end
        end
    end

    // ****************************************
    // Register writes.
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nsac_q <= `SVC_NSAC_RST;
        end else if (wr_ok && hit_nsac) begin
            nsac_q <= cp_wdata_in & nsac_wmask;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            virt_q <= `SVC_VIRT_RST;
        end else if (wr_ok && hit_virt) begin
            virt_q <= cp_wdata_in & `SVC_VIRT_WMASK;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpa_q <= `SVC_CPA_RST;
        end else if (wr_ok && hit_cpa) begin
            cpa_q <= (cpa_q & ~cpa_wmask) | (cp_wdata_in & cpa_wmask);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            coh_q <= 1'b0;
        end else if (wr_ok && hit_aux) begin
            coh_q <= cp_wdata_in[`SVC_AUX_COH];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tbc_s_q <= `SVC_TBC_RST;
        end else if (wr_ok && hit_tbc && !ns) begin
            tbc_s_q <= cp_wdata_in;
        end
    end

    // The non-secure copy has no reset; software must load it first.
    always_ff @(posedge clk_in) begin
        if (wr_ok && hit_tbc && ns) begin
            tbc_ns_q <= cp_wdata_in;
        end
    end

    // ****************************************
    // Answer and operations.
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cp_done_out <= 1'b0;
            cp_undef_out <= 1'b0;
            cp_rdata_out <= 32'h0;
            tlb_inv_out <= 1'b0;
            tlb_inv_kind_out <= SVC_TLBI_ALL;
            tlb_inv_hit_locked_out <= 1'b0;
            tlb_inv_shared_out <= 1'b0;
            tlb_inv_arg_out <= 32'h0;
            wait_for_interrupt_action_out <= 1'b0;
        end else begin
            cp_done_out <= cp_req_in;
            cp_undef_out <= cp_req_in && undef_d;
            cp_rdata_out <= rdata_d;
            tlb_inv_out <= wr_ok && hit_tlb;
            tlb_inv_kind_out <= tlb_kind;
            tlb_inv_hit_locked_out <= tlb_locked;
            tlb_inv_shared_out <= tlb_shared;
            tlb_inv_arg_out <= cp_wdata_in;
            wait_for_interrupt_action_out <= wr_ok && hit_nop;
        end
    end

    // ****************************************
    // Grants and exception takes.
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            copro_ten_ok_out <= 1'b0;
            copro_eleven_ok_out <= 1'b0;
            lockable_alloc_ok_out <= 1'b0;
            preload_ok_out <= 1'b0;
            coherency_participation_out <= 1'b0;
            vector_ext_disable_out <= 1'b0;
            upper_fp_bank_disable_out <= 1'b0;
        end else begin
            copro_ten_ok_out <= !ns || nsac_q[`SVC_NSAC_TEN];
            copro_eleven_ok_out <= !ns || nsac_q[`SVC_NSAC_ELEVEN];
            lockable_alloc_ok_out <= !ns || nsac_q[`SVC_NSAC_LOCK_ALLOC];
            preload_ok_out <= PRELOAD_PRESENT && (!ns || nsac_q[`SVC_NSAC_PRE]);
            coherency_participation_out <= coh_q;
            vector_ext_disable_out <= cpa_view[`SVC_CPA_VEC];
            upper_fp_bank_disable_out <= cpa_view[`SVC_CPA_FP];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            take_abort_out <= 1'b0;
            take_irq_out <= 1'b0;
            take_fiq_out <= 1'b0;
        end else begin
            take_abort_out <= pend_abort_in && (!mask_abort_in
                || (ns && route_abort_in && virt_q[`SVC_VIRT_ABT]));
            take_irq_out <= pend_irq_in && (!mask_irq_in
                || (ns && route_irq_in && virt_q[`SVC_VIRT_IRQ]));
            take_fiq_out <= pend_fiq_in && (!mask_fiq_in
                || (ns && route_fiq_in && virt_q[`SVC_VIRT_FIQ]));
        end
    end

    // ****************************************
    // Checks.
    // ****************************************
    AST_NSAC_NS_RO: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && cp_write_in && hit_nsac && ns |=> cp_undef_out && $stable(nsac_q))
        else $error("Non-secure write changed the access register.");
    AST_AUX_UNDEF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && cp_write_in && cp_priv_in && hit_aux && ns && !nsac_q[`SVC_NSAC_COH]
        |=> cp_undef_out && $stable(coh_q))
        else $error("Forbidden auxiliary write was not refused.");
    AST_AUX_COH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && cp_write_in && cp_priv_in && hit_aux && ns && nsac_q[`SVC_NSAC_COH]
        |=> !cp_undef_out && coh_q == $past(cp_wdata_in[`SVC_AUX_COH]))
        else $error("Permitted auxiliary write did not update coherency.");
    AST_LOCK_GRANT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ns && !nsac_q[`SVC_NSAC_LOCK_ALLOC] |=> !lockable_alloc_ok_out)
        else $error("Lockable allocation granted without permission.");
    AST_PRE_TRAP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && hit_pre && ns && !nsac_q[`SVC_NSAC_PRE] |=> cp_undef_out)
        else $error("Non-secure preload access was not trapped.");
    AST_PRE_ABSENT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        PRELOAD_PRESENT || !nsac_q[`SVC_NSAC_PRE])
        else $error("Preload bit set with no preload engine.");
    AST_VEC_FORCE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ns && nsac_q[`SVC_NSAC_VEC] ##1 ns && nsac_q[`SVC_NSAC_VEC] |-> vector_ext_disable_out)
        else $error("Vector disable not forced in non-secure state.");
    AST_VIRT_NS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && hit_virt && ns |=> cp_undef_out && $stable(virt_q))
        else $error("Non-secure virtualization access was not refused.");
    AST_IRQ_OVR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        pend_irq_in && mask_irq_in && ns && route_irq_in && virt_q[`SVC_VIRT_IRQ]
        |=> take_irq_out)
        else $error("Routed IRQ override was not honoured.");
    AST_OVR_SECURE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        mask_fiq_in && (!ns || !route_fiq_in) |=> !take_fiq_out)
        else $error("FIQ override acted while it should be ignored.");
    AST_TLB_ALL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        tlb_inv_out && (tlb_inv_kind_out == SVC_TLBI_ALL || tlb_inv_kind_out == SVC_TLBI_MVAA)
        |-> !tlb_inv_hit_locked_out)
        else $error("Invalidate-all touched locked entries.");
    AST_NOP_WAIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && cp_priv_in && hit_nop |=> wait_for_interrupt_action_out)
        else $error("No-operation slot did not wait.");
    AST_C4_NONE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        cp_req_in && cp_crn_in == `SVC_CRN_NONE |=> cp_undef_out)
        else $error("Access under c4 was accepted.");
endmodule

// >>> rtl/svc_tlb_decode.sv
`timescale 1ns/1ps
`include "svc_cfg.svh"
module svc_tlb_decode import svc_pkg::*; (
    input wire logic [3:0] crm_in,
    input wire logic [2:0] op2_in,
    output logic is_op_out,
    output svc_tlbi_t kind_out,
    output logic hit_locked_out,
    output logic shared_out
);
    // ****************************************
    // Translation cache operation decode.
    // ****************************************
    always_comb begin
        shared_out = (crm_in == `SVC_CRM_TLB_SHARED);
        is_op_out = !op2_in[2] && (shared_out ||
            (crm_in >= `SVC_CRM_TLB_LO && crm_in <= `SVC_CRM_TLB_HI));
        kind_out = svc_tlbi_t'(op2_in[1:0]);
        case (kind_out)
            SVC_TLBI_MVA, SVC_TLBI_ASID: hit_locked_out = 1'b1;
            default: hit_locked_out = 1'b0;
        endcase
    end
endmodule

// >>> verification/tb_secure_access_virt_ctrl_regs.sv
`timescale 1ns/1ps
`include "svc_cfg.svh"
module tb_secure_access_virt_ctrl_regs import svc_pkg::*;;
    // ****************************************
    // Stimulus and observed signals.
    // ****************************************
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [3:0] crn = 4'h0;
    logic [3:0] crm = 4'h0;
    logic [2:0] op2 = 3'h0;
    logic [2:0] op1 = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic priv = 1'b1;
    logic sec = 1'b1;
    logic [2:0] route = 3'h0;
    logic [2:0] mask = 3'h0;
    logic [2:0] pend = 3'h0;
    logic done, undef, ten_ok, eleven_ok, lock_ok, pre_ok, coh, vec_dis, fp_dis;
    logic tlb, hit, shared, wait_act;
    logic [2:0] take;
    logic [31:0] rdata, arg, rd, c_arg;
    logic [5:0] ops;
    svc_tlbi_t kind;
    int mismatches = 0;
    int compares = 0;

    // ****************************************
    // Design under test.
    // ****************************************
    svc_regs svc_regs_i (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .cp_req_in(req), .cp_write_in(wr),
        .cp_op1_in(op1), .cp_crn_in(crn), .cp_crm_in(crm), .cp_op2_in(op2),
        .cp_wdata_in(wdata), .cp_priv_in(priv), .secure_state_in(sec),
        .route_abort_in(route[2]), .route_irq_in(route[1]), .route_fiq_in(route[0]),
        .mask_abort_in(mask[2]), .mask_irq_in(mask[1]), .mask_fiq_in(mask[0]),
        .pend_abort_in(pend[2]), .pend_irq_in(pend[1]), .pend_fiq_in(pend[0]),
        .cp_done_out(done), .cp_undef_out(undef), .cp_rdata_out(rdata),
        .take_abort_out(take[2]), .take_irq_out(take[1]), .take_fiq_out(take[0]),
        .copro_ten_ok_out(ten_ok), .copro_eleven_ok_out(eleven_ok),
        .lockable_alloc_ok_out(lock_ok), .preload_ok_out(pre_ok),
        .coherency_participation_out(coh), .vector_ext_disable_out(vec_dis),
        .upper_fp_bank_disable_out(fp_dis), .tlb_inv_out(tlb), .tlb_inv_kind_out(kind),
        .tlb_inv_hit_locked_out(hit), .tlb_inv_shared_out(shared), .tlb_inv_arg_out(arg),
        .wait_for_interrupt_action_out(wait_act)
    );

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One coprocessor move; the answer stands in the cycle after the request.
    task automatic cp(input logic w, input logic [3:0] n, input logic [3:0] m,
                      input logic [2:0] o2, input logic [31:0] d, input logic eu);
        @(posedge clk_in);
        req <= 1'b1;
        wr <= w;
        crn <= n;
        crm <= m;
        op2 <= o2;
        wdata <= d;
        @(posedge clk_in);
        req <= 1'b0;
        #1;
        rd = rdata;
        c_arg = arg;
        ops = {tlb, kind, hit, shared, wait_act};
        check("response", {30'h0, done, undef}, {30'h0, 1'b1, eu});
    endtask

    task automatic ctx(input logic p, input logic s);
        @(posedge clk_in);
        priv <= p;
        sec <= s;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    task automatic ovr(input logic s, input logic [2:0] r, input logic [2:0] exp);
        @(posedge clk_in);
        sec <= s;
        route <= r;
        repeat (2) @(posedge clk_in);
        #1;
        check("take", {29'h0, take}, {29'h0, exp});
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset;
        cp(1'b0, 4'h1, 4'h1, 3'h2, 32'h0, 1'b0);
        check("access reset", rd, `SVC_NSAC_RST);
        cp(1'b0, 4'h1, 4'h1, 3'h3, 32'h0, 1'b0);
        check("virt reset", rd, `SVC_VIRT_RST);
        cp(1'b0, 4'h2, 4'h0, 3'h2, 32'h0, 1'b0);
        check("table control reset", rd, `SVC_TBC_RST);
        ctx(1'b1, 1'b0);
        check("ns grants", {28'h0, ten_ok, eleven_ok, lock_ok, pre_ok}, 32'h0);
        ctx(1'b1, 1'b1);
        check("s grants", {28'h0, ten_ok, eleven_ok, lock_ok, pre_ok}, 32'hf);
    endtask

    task automatic t_access;
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'hffff_ffff, 1'b0);
        cp(1'b0, 4'h1, 4'h1, 3'h2, 32'h0, 1'b0);
        check("access mask", rd, `SVC_NSAC_WMASK);
        ctx(1'b1, 1'b0);
        check("ns grants", {28'h0, ten_ok, eleven_ok, lock_ok, pre_ok}, 32'hf);
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0, 1'b1);
        cp(1'b0, 4'h1, 4'h1, 3'h2, 32'h0, 1'b0);
        check("access kept", rd, `SVC_NSAC_WMASK);
        ctx(1'b0, 1'b1);
        cp(1'b0, 4'h1, 4'h1, 3'h2, 32'h0, 1'b1);
        ctx(1'b1, 1'b1);
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0000_0400, 1'b0);
        ctx(1'b1, 1'b0);
        check("ten only", {28'h0, ten_ok, eleven_ok, lock_ok, pre_ok}, 32'h8);
        ctx(1'b1, 1'b1);
    endtask

    task automatic t_aux;
        cp(1'b1, 4'h1, 4'h0, 3'h1, 32'h0, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b1, 4'h1, 4'h0, 3'h1, 32'hffff_ffff, 1'b1);
        ctx(1'b1, 1'b0);
        check("coherency kept", {31'h0, coh}, 32'h0);
        ctx(1'b1, 1'b1);
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0004_0000, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b1, 4'h1, 4'h0, 3'h1, 32'hffff_ffff, 1'b0);
        cp(1'b0, 4'h1, 4'h0, 3'h1, 32'h0, 1'b0);
        check("aux only coherency", rd, 32'h0000_0040);
        check("coherency set", {31'h0, coh}, 32'h1);
        cp(1'b0, 4'hb, 4'h0, 3'h0, 32'h0, 1'b1);
        cp(1'b1, 4'hb, 4'h1, 3'h1, 32'h1, 1'b1);
        ctx(1'b1, 1'b1);
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0001_0000, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b0, 4'hb, 4'h0, 3'h0, 32'h0, 1'b0);
        check("preload reads zero", rd, 32'h0);
        ctx(1'b1, 1'b1);
    endtask

    task automatic t_coprocessor_access_control;
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0000_cc00, 1'b0);
        cp(1'b1, 4'h1, 4'h0, 3'h2, 32'h0, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b1, 4'h1, 4'h0, 3'h2, 32'h00f0_0000, 1'b0);
        cp(1'b0, 4'h1, 4'h0, 3'h2, 32'h0, 1'b0);
        check("ns coprocessor_access_control forced", rd, 32'hc0f0_0000);
        check("ns disables", {30'h0, vec_dis, fp_dis}, 32'h3);
        ctx(1'b1, 1'b1);
        cp(1'b0, 4'h1, 4'h0, 3'h2, 32'h0, 1'b0);
        check("s coprocessor_access_control", rd, 32'h00f0_0000);
        cp(1'b1, 4'h1, 4'h1, 3'h2, 32'h0, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b0, 4'h1, 4'h0, 3'h2, 32'h0, 1'b0);
        check("ns coprocessor_access_control unforced", rd, 32'h0);
        ctx(1'b1, 1'b1);
    endtask

    task automatic t_virt;
        ctx(1'b1, 1'b0);
        cp(1'b0, 4'h1, 4'h1, 3'h3, 32'h0, 1'b1);
        cp(1'b1, 4'h1, 4'h1, 3'h3, 32'hffff_ffff, 1'b1);
        ctx(1'b1, 1'b1);
        cp(1'b1, 4'h1, 4'h1, 3'h3, 32'hffff_ffff, 1'b0);
        cp(1'b0, 4'h1, 4'h1, 3'h3, 32'h0, 1'b0);
        check("virt mask", rd, `SVC_VIRT_WMASK);
        @(posedge clk_in);
        pend <= 3'h7;
        mask <= 3'h7;
        ovr(1'b1, 3'h7, 3'h0);
        ovr(1'b0, 3'h0, 3'h0);
        ovr(1'b0, 3'h5, 3'h5);
        ovr(1'b0, 3'h7, 3'h7);
        @(posedge clk_in);
        mask <= 3'h0;
        ovr(1'b1, 3'h0, 3'h7);
        cp(1'b1, 4'h1, 4'h1, 3'h3, 32'h0000_0080, 1'b0);
        @(posedge clk_in);
        mask <= 3'h7;
        ovr(1'b0, 3'h7, 3'h2);
        @(posedge clk_in);
        pend <= 3'h0;
        ovr(1'b1, 3'h0, 3'h0);
    endtask

    task automatic t_tbc;
        cp(1'b1, 4'h2, 4'h0, 3'h2, 32'h0000_0005, 1'b0);
        ctx(1'b1, 1'b0);
        cp(1'b1, 4'h2, 4'h0, 3'h2, 32'h0000_0003, 1'b0);
        cp(1'b0, 4'h2, 4'h0, 3'h2, 32'h0, 1'b0);
        check("ns table control", rd, 32'h0000_0003);
        ctx(1'b1, 1'b1);
        cp(1'b0, 4'h2, 4'h0, 3'h2, 32'h0, 1'b0);
        check("s table control", rd, 32'h0000_0005);
    endtask

    task automatic t_maint;
        for (int m = 0; m < 4; m++) begin
            for (int o = 0; o < 4; o++) begin
                logic [3:0] cm;
                logic [31:0] d;
                cm = (m == 0) ? 4'h3 : 4'(m + 4);
                d = {24'h5a_a500, cm, 4'(o)};
                cp(1'b1, 4'h8, cm, 3'(o), d, 1'b0);
                check("tlb op", {27'h0, ops[5:1]}, {28'h1, 2'(o), o == 1 || o == 2, cm == 4'h3});
                check("tlb arg", c_arg, d);
            end
        end
        cp(1'b1, 4'h7, 4'h0, 3'h4, 32'h0, 1'b0);
        check("wait action", {30'h0, ops[5], ops[0]}, 32'h1);
        for (int k = 0; k < 8; k++) begin
            cp(1'b1, 4'h4, 4'h0, 3'(k), 32'h0, 1'b1);
            cp(1'b0, 4'h4, 4'(k), 3'h0, 32'h0, 1'b1);
        end
        cp(1'b1, 4'h8, 4'h5, 3'h4, 32'h0, 1'b1);
        check("no tlb op", {31'h0, ops[5]}, 32'h0);
        @(posedge clk_in);
        op1 <= 3'h1;
        cp(1'b0, 4'h1, 4'h1, 3'h2, 32'h0, 1'b1);
        @(posedge clk_in);
        op1 <= 3'h0;
    endtask

    // ****************************************
    // Main sequence and watchdog.
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_access();
        t_aux();
        t_coprocessor_access_control();
        t_virt();
        t_tbc();
        t_maint();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        report_and_stop();
    end
endmodule
